// ### fscr_pkg.sv
// constants, field layout and state codes for the flash status/config block
// How it works
// - second status register read-only, hardware set
// - status bits 7,4,3,2 always read zero
// - bit 6 flags failed last erase
// - erase of protected sector/region sets erase fail
// - chip erase hitting protected sector sets fail
// - bit 5 flags failed last program
// - program into protected area sets program fail
// - only clear-status or soft reset clears fails; writes don't
// - bit 1 mirrors erase suspend, not writable
// - bit 0 mirrors program suspend, not writable
// - config one written by sixteen-cycle or any-register
// - bit 7 suspend default, zero, not programmable
// - bit 6 complement-protect default, ships zero
// - bits 5:2 one-time region locks refuse ops
// - bit 1 four-lane default, writable
// - bit 0 lock default, programmable only scheme 111
// - lock default set rejects register writes forever
// - error flag holds busy until clear-status or soft reset
package fscr_pkg;

  // command opcodes seen on the serial link
  localparam logic [7:0] OP_WRITE_REGS    = 8'h01;
  localparam logic [7:0] OP_READ_STAT_TWO = 8'h07;
  localparam logic [7:0] OP_READ_ANY      = 8'h65;
  localparam logic [7:0] OP_WRITE_ANY     = 8'h71;
  localparam logic [7:0] OP_NV_WR_ENABLE  = 8'h06;
  localparam logic [7:0] OP_CLEAR_STATUS  = 8'h30;

  // any-register addresses of the registers held here
  localparam logic [23:0] ADDR_STAT_TWO = 24'h000001;
  localparam logic [23:0] ADDR_CFG_NV   = 24'h000002;
  localparam logic [23:0] ADDR_CFG_LIVE = 24'h000003;

  // secondary status field positions
  localparam int STAT_ERASE_FAIL = 6;
  localparam int STAT_PROG_FAIL  = 5;
  localparam int STAT_ERASE_SUSP = 1;
  localparam int STAT_PROG_SUSP  = 0;

  // config one field positions
  localparam int CFG_HALT_DEF   = 7;
  localparam int CFG_INVERT     = 6;
  localparam int CFG_LOCK_HI    = 5;
  localparam int CFG_LOCK_LO    = 2;
  localparam int CFG_FOUR_LANE  = 1;
  localparam int CFG_REG_LOCK   = 0;

  // reset values and the scheme code that opens the lock default
  localparam logic [7:0] STAT_TWO_RESET = 8'h00;
  localparam logic [7:0] CFG_NV_RESET   = 8'h00;
  localparam logic [2:0] SCHEME_OPEN    = 3'h7;

  // bit counts of the frame phases
  localparam logic [5:0] BITS_BYTE  = 6'h08;
  localparam logic [5:0] BITS_ADDR  = 6'h18;
  localparam logic [5:0] BITS_WRR   = 6'h10;
  localparam logic [5:0] BITS_NONE  = 6'h00;

  // serial frame states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CMD   = 4'b0010,
    ST_ADDR  = 4'b0100,
    ST_DATA  = 4'b1000
  } fscr_state_e;

endpackage

// ### fscr_regs.sv
// flash secondary status and config one register bank with serial access
`timescale 1ns/1ps
`default_nettype none

module fscr_regs
  import fscr_pkg::*;
(
  input  wire logic       clock,                  // 250 MHz core clock
  input  wire logic       rst,                    // async, active high
  input  wire logic       soft_reset,             // one-cycle software reset
  input  wire logic       sclk,                   // link clock from host
  input  wire logic       cs_n,                   // chip select, low active
  input  wire logic       mosi,                   // host to device data
  output logic            miso_out,               // device to host data
  output logic            miso_oe,                // high while driving miso
  input  wire logic       erase_fail_evt,         // erase ended in error
  input  wire logic       program_fail_evt,       // program ended in error
  input  wire logic       sector_erase_protected, // erase hit locked sector
  input  wire logic       sector_prog_protected,  // program hit locked sector
  input  wire logic       chip_erase_protect_hit, // chip erase met lock
  input  wire logic       region_erase_req,       // erase of security region
  input  wire logic       region_program_req,     // program of region
  input  wire logic [1:0] region_sel,             // which security region
  input  wire logic       erase_suspend,          // erase suspended level
  input  wire logic       program_suspend,        // program suspended level
  input  wire logic [2:0] protection_scheme_select, // scheme field
  output logic            operation_busy_flag,    // busy indication
  output logic            region_op_refused,      // region op refused pulse
  output logic [3:0]      region_lock,            // live region locks
  output logic            halted_state_flag,      // live suspend status
  output logic            invert_protect_map,     // live complement bit
  output logic            four_lane_enable,       // live four-lane bit
  output logic            register_lock_live      // live register lock
);

  // link input synchronisers: meta stage feeds only the sync stage
  logic        sclk_meta_q;   // first stage, read by sync only
  logic        sclk_sync_q;   // usable sclk level
  logic        sclk_prev_q;   // for edge detect
  logic        cs_meta_q;     // first stage
  logic        cs_sync_q;     // usable select level
  logic        cs_prev_q;     // for frame end detect
  logic        mosi_meta_q;   // first stage
  logic        mosi_sync_q;   // usable data level

  // frame engine
  fscr_state_e state_q;       // frame phase
  logic [7:0]  opcode_q;      // received command
  logic [23:0] addr_q;        // received register address
  logic [15:0] wdata_q;       // received write bytes
  logic [5:0]  bitcnt_q;      // bits within current phase
  logic [7:0]  tx_q;          // read shift register
  logic        tx_skip_q;     // hold first bit across one fall

  // register state
  logic [7:0]  cfg_nv_q;      // non-volatile config one
  logic        erase_fail_q;  // status bit 6
  logic        prog_fail_q;   // status bit 5
  logic        erase_susp_q;  // status bit 1
  logic        prog_susp_q;   // status bit 0
  logic        wr_enable_q;   // non-volatile write enable latch
  logic        reload_q;      // live-load request after reset release
  logic        refused_q;     // registered refusal pulse

  // decoded events
  logic        sclk_rise;     // host sample edge
  logic        sclk_fall;     // device launch edge
  logic        frame_end;     // select just went high
  logic        in_frame;      // select low
  logic        reload;        // load live bits from defaults
  logic [7:0]  shifted;       // byte including current bit
  logic        exec_wrr;      // complete sixteen-cycle write
  logic        exec_write_any_register_cmd;     // complete any-register write to nv
  logic        exec_clear;    // clear-status command
  logic        exec_nonvolatile_write_enable_cmd;     // write-enable command
  logic        nv_write;      // accepted write of config one
  logic [7:0]  nv_wdata;      // byte aimed at config one
  logic [7:0]  stat_two;      // assembled status view
  logic [7:0]  cfg_live;      // assembled live config view
  logic [7:0]  read_sel;      // byte chosen for a read
  logic        region_locked; // addressed region has its lock set
  logic        erase_set;     // any erase error cause
  logic        prog_set;      // any program error cause

  // two-flop capture of every link pin before use
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_meta_q <= 1'b0;
      sclk_sync_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      cs_meta_q   <= 1'b1;
      cs_sync_q   <= 1'b1;
      cs_prev_q   <= 1'b1;
      mosi_meta_q <= 1'b0;
      mosi_sync_q <= 1'b0;
    end else begin
      sclk_meta_q <= sclk;
      sclk_sync_q <= sclk_meta_q;
      sclk_prev_q <= sclk_sync_q;
      cs_meta_q   <= cs_n;
      cs_sync_q   <= cs_meta_q;
      cs_prev_q   <= cs_sync_q;
      mosi_meta_q <= mosi;
      mosi_sync_q <= mosi_meta_q;
    end
  end

  // edges seen only on the synchronised copies
  assign in_frame  = ~cs_sync_q;
  assign sclk_rise = in_frame & sclk_sync_q & ~sclk_prev_q;
  assign sclk_fall = in_frame & ~sclk_sync_q & sclk_prev_q;
  assign frame_end = cs_sync_q & ~cs_prev_q;
  assign shifted   = {wdata_q[6:0], mosi_sync_q};

  // status view: reserved bits tie to zero
  always_comb begin
    stat_two                  = STAT_TWO_RESET;
    stat_two[STAT_ERASE_FAIL] = erase_fail_q;
    stat_two[STAT_PROG_FAIL]  = prog_fail_q;
    stat_two[STAT_ERASE_SUSP] = erase_susp_q;
    stat_two[STAT_PROG_SUSP]  = prog_susp_q;
  end

  // live config view for any-register reads
  always_comb begin
    cfg_live                          = CFG_NV_RESET;
    cfg_live[CFG_HALT_DEF]            = halted_state_flag;
    cfg_live[CFG_INVERT]              = invert_protect_map;
    cfg_live[CFG_LOCK_HI:CFG_LOCK_LO] = region_lock;
    cfg_live[CFG_FOUR_LANE]           = four_lane_enable;
    cfg_live[CFG_REG_LOCK]            = register_lock_live;
  end

  // read mux; unknown addresses return zero
  always_comb begin
    if (opcode_q == OP_READ_STAT_TWO) begin
      read_sel = stat_two;
    end else begin
      case ({addr_q[22:0], mosi_sync_q})
        ADDR_STAT_TWO: read_sel = stat_two;
        ADDR_CFG_NV:   read_sel = cfg_nv_q;
        ADDR_CFG_LIVE: read_sel = cfg_live;
        default:       read_sel = 8'h00;
      endcase
    end
  end

  // frame phases; a frame aborted early just returns to idle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q  <= ST_IDLE;
      opcode_q <= 8'h00;
      addr_q   <= 24'h000000;
      wdata_q  <= 16'h0000;
      bitcnt_q <= BITS_NONE;
    end else if (!in_frame) begin
      state_q  <= ST_IDLE;
      bitcnt_q <= BITS_NONE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // select fell: start collecting the opcode
          state_q  <= ST_CMD;
          bitcnt_q <= BITS_NONE;
          wdata_q  <= 16'h0000;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            wdata_q[7:0] <= shifted;
            if (bitcnt_q == BITS_BYTE - 6'h01) begin
              opcode_q <= shifted;
              bitcnt_q <= BITS_NONE;
              wdata_q  <= 16'h0000;
              if (shifted == OP_READ_ANY || shifted == OP_WRITE_ANY) begin
                state_q <= ST_ADDR;
              end else begin
                // reads, writes and bare commands share the data phase
                state_q <= ST_DATA;
              end
            end else begin
              bitcnt_q <= bitcnt_q + 6'h01;
            end
          end
        end
        ST_ADDR: begin
          if (sclk_rise) begin
            addr_q <= {addr_q[22:0], mosi_sync_q};
            if (bitcnt_q == BITS_ADDR - 6'h01) begin
              bitcnt_q <= BITS_NONE;
              state_q  <= ST_DATA;
            end else begin
              bitcnt_q <= bitcnt_q + 6'h01;
            end
          end
        end
        ST_DATA: begin
          // count stops one past sixteen so longer frames are rejected
          if (sclk_rise) begin
            wdata_q <= {wdata_q[14:0], mosi_sync_q};
            if (bitcnt_q <= BITS_WRR) begin
              bitcnt_q <= bitcnt_q + 6'h01;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // read shifter: loaded on the last header bit, launched on falls
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_q      <= 8'h00;
      tx_skip_q <= 1'b0;
    end else if (sclk_rise && state_q == ST_CMD &&
                 bitcnt_q == BITS_BYTE - 6'h01 &&
                 shifted == OP_READ_STAT_TWO) begin
      tx_q      <= stat_two;
      tx_skip_q <= 1'b1;
    end else if (sclk_rise && state_q == ST_ADDR &&
                 bitcnt_q == BITS_ADDR - 6'h01 &&
                 opcode_q == OP_READ_ANY) begin
      tx_q      <= read_sel;
      tx_skip_q <= 1'b1;
    end else if (sclk_fall) begin
      // the fall right after loading would drop bit 7 early
      if (tx_skip_q) begin
        tx_skip_q <= 1'b0;
      end else begin
        // snapshot repeats if the host keeps clocking
        tx_q <= {tx_q[6:0], tx_q[7]};
      end
    end
  end

  assign miso_out = tx_q[7];
  assign miso_oe  = in_frame && state_q == ST_DATA &&
                    (opcode_q == OP_READ_STAT_TWO ||
                     opcode_q == OP_READ_ANY);

  // commands take effect only when select rises with exact bit counts
  assign exec_wrr   = frame_end && state_q == ST_DATA &&
                      opcode_q == OP_WRITE_REGS &&
                      bitcnt_q == BITS_WRR;
  assign exec_write_any_register_cmd  = frame_end && state_q == ST_DATA &&
                      opcode_q == OP_WRITE_ANY &&
                      bitcnt_q == BITS_BYTE &&
                      addr_q == ADDR_CFG_NV;
  assign exec_clear = frame_end && state_q == ST_DATA &&
                      opcode_q == OP_CLEAR_STATUS &&
                      bitcnt_q == BITS_NONE;
  assign exec_nonvolatile_write_enable_cmd  = frame_end && state_q == ST_DATA &&
                      opcode_q == OP_NV_WR_ENABLE &&
                      bitcnt_q == BITS_NONE;

  // sixteen-cycle write: first byte is the other status register
  assign nv_wdata = wdata_q[7:0];

  // write allowed: enabled, not busy, and no register lock in force
  assign nv_write = (exec_wrr | exec_write_any_register_cmd) & wr_enable_q &
                    ~operation_busy_flag &
                    ~cfg_nv_q[CFG_REG_LOCK] &
                    ~register_lock_live;

  // write-enable latch, dropped by a completed write or clear-status
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_enable_q <= 1'b0;
    end else if (soft_reset || exec_clear || nv_write) begin
      wr_enable_q <= 1'b0;
    end else if (exec_nonvolatile_write_enable_cmd && !operation_busy_flag) begin
      wr_enable_q <= 1'b1;
    end
  end

  // non-volatile config one, field by field
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_nv_q <= CFG_NV_RESET;
    end else if (nv_write) begin
      // suspend default is never programmable
      cfg_nv_q[CFG_HALT_DEF] <= cfg_nv_q[CFG_HALT_DEF];
      cfg_nv_q[CFG_INVERT]   <= nv_wdata[CFG_INVERT];
      // one-time locks may only go from zero to one
      cfg_nv_q[CFG_LOCK_HI:CFG_LOCK_LO] <=
        cfg_nv_q[CFG_LOCK_HI:CFG_LOCK_LO] |
        nv_wdata[CFG_LOCK_HI:CFG_LOCK_LO];
      cfg_nv_q[CFG_FOUR_LANE] <= nv_wdata[CFG_FOUR_LANE];
      cfg_nv_q[CFG_REG_LOCK]  <= cfg_nv_q[CFG_REG_LOCK] |
        (nv_wdata[CFG_REG_LOCK] &
         (protection_scheme_select == SCHEME_OPEN));
    end
  end

  // live bits load after reset release, never under the reset itself
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reload_q <= 1'b1;
    end else begin
      reload_q <= 1'b0;
    end
  end
  assign reload = reload_q | soft_reset;

  // live copies of the defaults; writes to the nv copy follow through, except the register lock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      invert_protect_map <= 1'b0;
      four_lane_enable   <= 1'b0;
      register_lock_live <= 1'b0;
    end else if (reload) begin
      invert_protect_map <= cfg_nv_q[CFG_INVERT];
      four_lane_enable   <= cfg_nv_q[CFG_FOUR_LANE];
      register_lock_live <= cfg_nv_q[CFG_REG_LOCK];
    end else if (nv_write) begin
      invert_protect_map <= nv_wdata[CFG_INVERT];
      four_lane_enable   <= nv_wdata[CFG_FOUR_LANE];
    end
  end

  // region locks track the one-time bits directly
  assign region_lock = cfg_nv_q[CFG_LOCK_HI:CFG_LOCK_LO];

  // suspend status: default on reload, else follows the suspend levels
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      halted_state_flag <= 1'b0;
      erase_susp_q      <= 1'b0;
      prog_susp_q       <= 1'b0;
    end else if (reload) begin
      halted_state_flag <= cfg_nv_q[CFG_HALT_DEF];
      erase_susp_q      <= 1'b0;
      prog_susp_q       <= 1'b0;
    end else begin
      halted_state_flag <= erase_susp_q | prog_susp_q;
      erase_susp_q      <= erase_suspend;
      prog_susp_q       <= program_suspend;
    end
  end

  // security-region requests against the addressed lock
  assign region_locked = region_lock[region_sel];

  // error causes; locked-region requests count only when not busy
  assign erase_set = erase_fail_evt | sector_erase_protected |
                     chip_erase_protect_hit |
                     (region_erase_req & region_locked &
                      ~operation_busy_flag);
  assign prog_set  = program_fail_evt | sector_prog_protected |
                     (region_program_req & region_locked &
                      ~operation_busy_flag);

  // sticky fail flags: a new error wins over a clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      erase_fail_q <= 1'b0;
      prog_fail_q  <= 1'b0;
    end else begin
      if (erase_set) begin
        erase_fail_q <= 1'b1;
      end else if (exec_clear || soft_reset) begin
        erase_fail_q <= 1'b0;
      end
      if (prog_set) begin
        prog_fail_q <= 1'b1;
      end else if (exec_clear || soft_reset) begin
        prog_fail_q <= 1'b0;
      end
    end
  end

  // busy holds while either fail flag stands
  assign operation_busy_flag = erase_fail_q | prog_fail_q;

  // refusal pulse for region requests that are locked or blocked by busy
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= (region_erase_req | region_program_req) &
                   (region_locked | operation_busy_flag);
    end
  end
  assign region_op_refused = refused_q;

endmodule

`default_nettype wire

// ### fscr_regs_sva.sv
// checker for the flash status/config block, port relations only
`timescale 1ns/1ps
`default_nettype none
module fscr_regs_sva
  import fscr_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       soft_reset,
  input wire logic       cs_n,
  input wire logic       erase_fail_evt,
  input wire logic       program_fail_evt,
  input wire logic       sector_erase_protected,
  input wire logic       sector_prog_protected,
  input wire logic       chip_erase_protect_hit,
  input wire logic       region_erase_req,
  input wire logic       region_program_req,
  input wire logic [1:0] region_sel,
  input wire logic       erase_suspend,
  input wire logic       program_suspend,
  input wire logic       operation_busy_flag,
  input wire logic       region_op_refused,
  input wire logic [3:0] region_lock,
  input wire logic       halted_state_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // every failure source must leave the part busy one cycle later
  a_erase_busy:
    assert property (erase_fail_evt |=> operation_busy_flag)
    else $error("busy missing after erase failure");
  a_prog_busy:
    assert property (program_fail_evt |=> operation_busy_flag)
    else $error("busy missing after program failure");
  a_sector_erase:
    assert property (sector_erase_protected |=> operation_busy_flag)
    else $error("busy missing after protected erase");
  a_sector_prog:
    assert property (sector_prog_protected |=> operation_busy_flag)
    else $error("busy missing after protected program");
  a_chip_erase:
    assert property (chip_erase_protect_hit |=> operation_busy_flag)
    else $error("busy missing after chip erase hit");
  // busy only drops after a frame has closed or on software reset
  a_busy_hold:
    assert property ($fell(operation_busy_flag) |->
      (cs_n && $past(cs_n, 2)) || $past(soft_reset))
    else $error("busy dropped inside a frame");
  // suspend status sits two register stages behind the suspend levels
  a_halt_track:
    assert property (!$past(soft_reset) && !$past(soft_reset, 2) |->
      halted_state_flag == $past(erase_suspend || program_suspend, 2))
    else $error("suspend status does not follow suspend levels");
  a_lock_refuse:
    assert property (region_erase_req && region_lock[region_sel] &&
      !operation_busy_flag |=> region_op_refused && operation_busy_flag)
    else $error("locked region erase not refused");
  a_free_region:
    assert property ((region_erase_req || region_program_req) &&
      !region_lock[region_sel] && !operation_busy_flag |=>
      !region_op_refused)
    else $error("unlocked region request refused");
endmodule
`default_nettype wire

// ### fscr_host.sv
// serial host model issuing register frames, mode 0, MSB first
`timescale 1ns/1ps
`default_nettype none
module fscr_host (
  output logic sclk,     // link clock, still between frames
  output logic cs_n,     // chip select, low active
  output logic mosi,     // host data out
  input  wire logic miso_out, // device data
  input  wire logic miso_oe   // device drive enable
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // sends op plus nb data bits, then clocks in nr bits
  task automatic frame(input logic [7:0] op, input logic [31:0] dat,
                       input int nb, input int nr, output logic [7:0] rd);
    logic [39:0] sh;
    // left-align the nb data bits under the opcode, which stays on top
    sh = {op, dat << (32 - nb)};
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < 8 + nb + nr; i++) begin
      // data changes on the fall; past the write part it toggles
      mosi = (i < 8 + nb) ? sh[39 - i] : ~mosi;
      #16 sclk = 1'b1;
      // an undriven line reads back inverted, never a lucky match
      if (i >= 8 + nb)
        rd = {rd[6:0], miso_oe ? miso_out : ~rd[0]};
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    mosi = ~mosi;
    #40;
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench for the flash status/config register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fscr_pkg::*;
  logic       clock, rst, soft_reset;
  wire        sclk, cs_n, mosi;
  logic       miso_out, miso_oe, operation_busy_flag, region_op_refused;
  logic       halted_state_flag, invert_protect_map, four_lane_enable;
  logic       register_lock_live;
  logic [3:0] region_lock;
  logic [4:0] evt;      // erase, program, sec erase, sec prog, chip
  logic [1:0] rreq;     // region erase, region program
  logic [1:0] susp;     // program suspend, erase suspend
  logic [1:0] region_sel;
  logic [2:0] protection_scheme_select;
  int         miscompares, checked, cyc;
  fscr_host host (.sclk, .cs_n, .mosi, .miso_out, .miso_oe);
  fscr_regs DUT (.clock, .rst, .soft_reset, .sclk, .cs_n, .mosi,
    .miso_out, .miso_oe, .erase_fail_evt(evt[0]),
    .program_fail_evt(evt[1]), .sector_erase_protected(evt[2]),
    .sector_prog_protected(evt[3]), .chip_erase_protect_hit(evt[4]),
    .region_erase_req(rreq[0]), .region_program_req(rreq[1]),
    .region_sel, .erase_suspend(susp[1]), .program_suspend(susp[0]),
    .protection_scheme_select, .operation_busy_flag, .region_op_refused,
    .region_lock, .halted_state_flag, .invert_protect_map,
    .four_lane_enable, .register_lock_live);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd_any(input logic [23:0] a, output logic [7:0] v);
    host.frame(OP_READ_ANY, {8'h00, a}, 24, 8, v);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [31:0] d,
                     input int nb);
    logic [7:0] v;
    host.frame(op, d, nb, 0, v);
  endtask
  task automatic stat(input logic [7:0] exp);
    logic [7:0] v;
    host.frame(OP_READ_STAT_TWO, 32'h0, 0, 8, v);
    chk(v, exp);
  endtask
  task automatic t_reset;
    logic [7:0] v;
    stat(STAT_TWO_RESET);
    rd_any(ADDR_CFG_NV, v);
    chk(v, CFG_NV_RESET);
    $display("test reset done");
  endtask
  task automatic t_events;
    logic [7:0] v;
    logic [7:0] exp [5] = '{8'h40, 8'h20, 8'h40, 8'h20, 8'h40};
    for (int k = 0; k < 5; k++) begin
      @(negedge clock) evt[k] = 1'b1;
      @(negedge clock) evt[k] = 1'b0;
      stat(exp[k]);
      chk({7'h0, operation_busy_flag}, 8'h01);
      cmd(OP_NV_WR_ENABLE, 32'h0, 0);
      cmd(OP_WRITE_ANY, {ADDR_CFG_NV, 8'h42}, 32);
      rd_any(ADDR_STAT_TWO, v);
      chk(v, exp[k]);
      rd_any(ADDR_CFG_NV, v);
      chk(v, CFG_NV_RESET);
      cmd(OP_CLEAR_STATUS, 32'h0, 0);
      stat(8'h00);
      chk({7'h0, operation_busy_flag}, 8'h00);
    end
    $display("test events done");
  endtask
  task automatic t_susp;
    for (int k = 1; k < 4; k++) begin
      @(negedge clock) susp = 2'(k);
      stat({6'h0, 2'(k)});
      chk({7'h0, halted_state_flag}, 8'h01);
    end
    cmd(OP_NV_WR_ENABLE, 32'h0, 0);
    cmd(OP_WRITE_ANY, {ADDR_STAT_TWO, 8'h00}, 32);
    stat(8'h03);
    @(negedge clock) susp = 2'b00;
    stat(8'h00);
    $display("test suspend done");
  endtask
  task automatic t_cfg;
    logic [7:0] v;
    cmd(OP_NV_WR_ENABLE, 32'h0, 0);
    cmd(OP_WRITE_REGS, 32'h0000ffcf, 16);
    rd_any(ADDR_CFG_NV, v);
    chk(v, 8'h4e);
    chk({4'h0, region_lock}, 8'h03);
    chk({6'h0, invert_protect_map, four_lane_enable}, 8'h03);
    @(negedge clock) rreq = 2'b01;
    @(negedge clock) rreq = 2'b00;
    chk({7'h0, region_op_refused}, 8'h01);
    stat(8'h40);
    cmd(OP_CLEAR_STATUS, 32'h0, 0);
    @(negedge clock) region_sel = 2'h3;
    rreq = 2'b10;
    @(negedge clock) rreq = 2'b00;
    chk({7'h0, region_op_refused}, 8'h00);
    stat(8'h00);
    protection_scheme_select = SCHEME_OPEN;
    cmd(OP_NV_WR_ENABLE, 32'h0, 0);
    cmd(OP_WRITE_ANY, {ADDR_CFG_NV, 8'h01}, 32);
    rd_any(ADDR_CFG_NV, v);
    chk(v, 8'h0d);
    chk({6'h0, invert_protect_map, four_lane_enable}, 8'h00);
    @(negedge clock) soft_reset = 1'b1;
    @(negedge clock) soft_reset = 1'b0;
    chk({7'h0, register_lock_live}, 8'h01);
    rd_any(ADDR_CFG_LIVE, v);
    chk(v, 8'h0d);
    cmd(OP_NV_WR_ENABLE, 32'h0, 0);
    cmd(OP_WRITE_ANY, {ADDR_CFG_NV, 8'h40}, 32);
    rd_any(ADDR_CFG_NV, v);
    chk(v, 8'h0d);
    $display("test config done");
  endtask
  task automatic end_of_test;
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard, well above the roughly 12000 cycles the tests need
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      end_of_test;
    end
  end
  initial begin
    rst = 1'b1;
    soft_reset = 1'b0;
    evt = 5'h00;
    rreq = 2'b00;
    susp = 2'b00;
    region_sel = 2'h0;
    protection_scheme_select = 3'h0;
    miscompares = 0;
    checked = 0;
    cyc = 0;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    t_reset;
    t_events;
    t_susp;
    t_cfg;
    end_of_test;
  end
endmodule
bind fscr_regs fscr_regs_sva u_sva (.clock, .rst, .soft_reset, .cs_n,
  .erase_fail_evt, .program_fail_evt, .sector_erase_protected,
  .sector_prog_protected, .chip_erase_protect_hit, .region_erase_req,
  .region_program_req, .region_sel, .erase_suspend, .program_suspend,
  .operation_busy_flag, .region_op_refused, .region_lock,
  .halted_state_flag);
`default_nettype wire
